// ---- logic/iomfs_core.sv ----
// cyclic io word mapper with communication-loss fail-safe writer
//
// Function
// - timeout time held in steps of one hundredth second
// - timeout time is ten seconds after reset
// - silence reaching timeout time raises one timeout processing event
// - fail-safe table of ten register and value pairs
// - entries with register number zero are skipped
// - nonzero entries write their value into the named register
// - all fail-safe register numbers are zero after reset
// - bit 0 of the optional 32-bit header is the run flag
// - idle with option clear keeps last applied output data
// - idle with option set starts fail-safe processing
// - user map serves only instances 100 and 150
// - one consumed and one produced map of thirty-two slots
// - each slot is one 16-bit word of payload
// - slot n belongs to payload word n
// - empty slot discards consumed word, produces zero
// - words beyond the map are discarded or sent as zero
// - consumed map resets to registers 1007 and 1008
// - produced map resets to registers 1402 and 1401
// - settings take effect only after commit and restart
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module iomfs_core #(
  parameter int MAP_SLOTS = 32,
  parameter int FS_ENTRIES = 10,
  parameter longint TICK_CYC = iomfs_pkg::TMO_STEP_CYC,
  parameter longint RESTART_CYC = iomfs_pkg::RESTART_CYC
) (
  input wire logic clk_i, // 250 MHz clock
  input wire logic rst_i, // sync reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write
  input wire logic [9:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic rx_sof_i, // start of consumed packet
  input wire logic [7:0] rx_inst_i, // assembly instance
  input wire logic rx_hdr_vld_i, // run/idle header present
  input wire logic [31:0] rx_hdr_i, // run/idle header
  input wire logic rx_word_vld_i, // consumed word strobe
  input wire logic [15:0] rx_word_i, // consumed word
  input wire logic tx_req_i, // produced word request
  input wire logic [7:0] tx_inst_i, // assembly instance
  input wire logic [5:0] tx_idx_i, // produced word index
  output logic tx_vld_o, // produced word valid
  output logic [15:0] tx_word_o, // produced word
  output logic drv_wr_o, // drive register write
  output logic [15:0] drv_waddr_o, // written register number
  output logic [15:0] drv_wdata_o, // written value
  output logic drv_rd_o, // drive register read
  output logic [15:0] drv_raddr_o, // read register number
  input wire logic [15:0] drv_rdata_i, // read value, while rd high
  output logic fs_event_o, // timeout processing started
  output logic online_o // running on loaded settings
);
  localparam logic [5:0] SLOTS6 = 6'(MAP_SLOTS);
  localparam logic [3:0] FS_LAST = 4'(FS_ENTRIES - 1);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);
  localparam logic [32:0] RESTART_LAST = 33'(RESTART_CYC - 1);
  localparam int FS_REG_LSB = iomfs_pkg::FS_REG_LSB;
  localparam int FS_VAL_LSB = iomfs_pkg::FS_VAL_LSB;
  localparam logic [9:0] OFS_CTRL = iomfs_pkg::OFS_CTRL;
  localparam logic [9:0] OFS_TMO = iomfs_pkg::OFS_TMO;
  localparam logic [9:0] OFS_STAT = iomfs_pkg::OFS_STAT;
  localparam logic [9:0] OFS_FS = iomfs_pkg::OFS_FS;
  localparam logic [9:0] OFS_CMAP = iomfs_pkg::OFS_CMAP;
  localparam logic [9:0] OFS_PMAP = iomfs_pkg::OFS_PMAP;

  if (MAP_SLOTS < 2 || MAP_SLOTS > 32 || FS_ENTRIES < 1 ||
      FS_ENTRIES > 16 || TICK_CYC < 1 || RESTART_CYC < 1 ||
      TICK_CYC > 64'h0000_0000_FFFF_FFFF ||
      RESTART_CYC > 64'h0000_0001_FFFF_FFFF) begin : g_chk
    $error("iomfs_core: parameter out of range");
  end

  typedef enum logic [0:0] {WALK_IDLE, WALK_RUN} iomfs_walk_type;

  typedef struct packed {
    logic stg_idle_fs;
    logic [15:0] stg_tmo;
    logic [FS_ENTRIES-1:0][31:0] stg_fs;
    logic [MAP_SLOTS-1:0][15:0] stg_cmap;
    logic [MAP_SLOTS-1:0][15:0] stg_pmap;
    logic act_idle_fs;
    logic [15:0] act_tmo;
    logic [FS_ENTRIES-1:0][31:0] act_fs;
    logic [MAP_SLOTS-1:0][15:0] act_cmap;
    logic [MAP_SLOTS-1:0][15:0] act_pmap;
    logic offline;
    logic [32:0] rst_cnt;
    logic [31:0] tick_cnt;
    logic [15:0] silence;
    logic armed;
    logic lost;
    logic was_idle;
    iomfs_walk_type walk;
    logic [3:0] fs_idx;
    logic [5:0] rx_idx;
    logic rx_map;
    logic tx_pend;
    logic tx_zero;
    logic wr_fs;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic tx_vld;
    logic [15:0] tx_word;
    logic drv_wr;
    logic [15:0] drv_waddr;
    logic [15:0] drv_wdata;
    logic drv_rd;
    logic [15:0] drv_raddr;
    logic fs_evt;
  } iomfs_state_type;

  iomfs_state_type s;
  iomfs_state_type next_s;
  logic [7:0] widx;
  logic bus_req;
  logic cons_wr;
  logic tick;
  logic idle_now;
  logic trig;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign widx = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !s.wb_ack;
  assign tick = (s.tick_cnt == TICK_LAST);
  assign idle_now = rx_hdr_vld_i && !rx_hdr_i[0];
  // slot n takes word n when mapped
  assign cons_wr = !s.offline && rx_word_vld_i && s.rx_map &&
                   (s.rx_idx < SLOTS6) &&
                   (s.act_cmap[s.rx_idx[4:0]] != 16'h0000);
  assign trig = !s.offline &&
                ((rx_sof_i && idle_now && !s.was_idle && s.act_idle_fs) ||
                 (!rx_sof_i && tick && s.armed && !s.lost &&
                  s.act_tmo != 16'h0000 &&
                  (s.silence + 16'h0001) >= s.act_tmo));

  //----------------------------------------------------------------
  // next state
  //----------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [7:0] k;
    next_s = s;
    rd = 32'h0000_0000;
    k = 8'h00;
    next_s.wb_ack = 1'b0;
    next_s.drv_wr = 1'b0;
    next_s.drv_rd = 1'b0;
    next_s.tx_vld = 1'b0;
    next_s.tx_pend = 1'b0;
    next_s.fs_evt = 1'b0;
    next_s.wr_fs = 1'b0;
    // register bus, one wait state
    if (bus_req) begin
      next_s.wb_ack = 1'b1;
      if (widx == OFS_CTRL[9:2]) begin
        rd[iomfs_pkg::CTRL_IDLE_FS_BIT] = s.stg_idle_fs;
      end else if (widx == OFS_TMO[9:2]) begin
        rd = {16'h0000, s.stg_tmo};
      end else if (widx == OFS_STAT[9:2]) begin
        rd[iomfs_pkg::STAT_OFFLINE_BIT] = s.offline;
        rd[iomfs_pkg::STAT_ARMED_BIT] = s.armed;
        rd[iomfs_pkg::STAT_LOST_BIT] = s.lost;
        rd[iomfs_pkg::STAT_WALK_BIT] = (s.walk == WALK_RUN);
        rd[iomfs_pkg::STAT_IDLE_BIT] = s.was_idle;
      end else if (widx >= OFS_FS[9:2] &&
                   widx < OFS_FS[9:2] + 8'(FS_ENTRIES)) begin
        k = widx - OFS_FS[9:2];
        rd = s.stg_fs[k[3:0]];
        if (wb_we_i) begin
          next_s.stg_fs[k[3:0]] = merge(rd, wb_dat_i, wb_sel_i);
        end
      end else if (widx >= OFS_CMAP[9:2] &&
                   widx < OFS_CMAP[9:2] + 8'(MAP_SLOTS)) begin
        k = widx - OFS_CMAP[9:2];
        rd = {16'h0000, s.stg_cmap[k[4:0]]};
        if (wb_we_i) begin
          next_s.stg_cmap[k[4:0]] = 16'(merge(rd, wb_dat_i, wb_sel_i));
        end
      end else if (widx >= OFS_PMAP[9:2] &&
                   widx < OFS_PMAP[9:2] + 8'(MAP_SLOTS)) begin
        k = widx - OFS_PMAP[9:2];
        rd = {16'h0000, s.stg_pmap[k[4:0]]};
        if (wb_we_i) begin
          next_s.stg_pmap[k[4:0]] = 16'(merge(rd, wb_dat_i, wb_sel_i));
        end
      end
      if (wb_we_i && widx == OFS_CTRL[9:2] && wb_sel_i[0]) begin
        next_s.stg_idle_fs = wb_dat_i[iomfs_pkg::CTRL_IDLE_FS_BIT];
        if (wb_dat_i[iomfs_pkg::CTRL_COMMIT_BIT]) begin
          next_s.offline = 1'b1;
          next_s.rst_cnt = 33'h0_0000_0000;
        end
      end
      if (wb_we_i && widx == OFS_TMO[9:2]) begin
        next_s.stg_tmo = 16'(merge({16'h0000, s.stg_tmo}, wb_dat_i,
                                   {2'b00, wb_sel_i[1:0]}));
      end
      next_s.wb_dat = wb_we_i ? 32'h0000_0000 : rd;
    end
    if (s.offline) begin
      // settings load only when restart completes
      next_s.rst_cnt = s.rst_cnt + 33'h0_0000_0001;
      if (s.rst_cnt == RESTART_LAST) begin
        next_s.offline = 1'b0;
        next_s.act_idle_fs = s.stg_idle_fs;
        next_s.act_tmo = s.stg_tmo;
        next_s.act_fs = s.stg_fs;
        next_s.act_cmap = s.stg_cmap;
        next_s.act_pmap = s.stg_pmap;
        next_s.armed = 1'b0;
        next_s.lost = 1'b0;
        next_s.was_idle = 1'b0;
        next_s.rx_map = 1'b0;
        next_s.walk = WALK_IDLE;
      end
    end else begin
      next_s.tick_cnt = tick ? 32'h0000_0000 : s.tick_cnt + 32'h0000_0001;
      if (rx_sof_i) begin
        // idle packets never map their words; with the idle option set the fail-safe walk writes its table
        next_s.rx_idx = 6'h00;
        next_s.rx_map = (rx_inst_i == iomfs_pkg::CONS_INST) && !idle_now;
        next_s.armed = 1'b1;
        next_s.lost = 1'b0;
        next_s.silence = 16'h0000;
        next_s.was_idle = idle_now;
      end else begin
        if (tick && s.armed && !s.lost) begin
          next_s.silence = s.silence + 16'h0001;
        end
        if (trig) begin
          next_s.lost = 1'b1;
        end
        if (rx_word_vld_i && s.rx_idx < SLOTS6) begin
          next_s.rx_idx = s.rx_idx + 6'h01;
        end
      end
      if (cons_wr) begin
        next_s.drv_wr = 1'b1;
        next_s.drv_waddr = s.act_cmap[s.rx_idx[4:0]];
        next_s.drv_wdata = rx_word_i;
      end else if (s.walk == WALK_RUN) begin
        if (s.act_fs[s.fs_idx][FS_VAL_LSB-1:FS_REG_LSB] != 16'h0000) begin
          next_s.drv_wr = 1'b1;
          next_s.wr_fs = 1'b1;
          next_s.drv_waddr = s.act_fs[s.fs_idx][FS_VAL_LSB-1:FS_REG_LSB];
          next_s.drv_wdata = s.act_fs[s.fs_idx][31:FS_VAL_LSB];
        end
        next_s.fs_idx = s.fs_idx + 4'h1;
        if (s.fs_idx == FS_LAST) begin
          next_s.walk = WALK_IDLE;
        end
      end
      if (trig) begin
        next_s.fs_evt = 1'b1;
        next_s.walk = WALK_RUN;
        next_s.fs_idx = 4'h0;
      end
      if (tx_req_i) begin
        // zero answers share the read latency, back to back stays ordered
        next_s.tx_pend = 1'b1;
        next_s.tx_zero = 1'b1;
        if (tx_inst_i == iomfs_pkg::PROD_INST && tx_idx_i < SLOTS6 &&
            s.act_pmap[tx_idx_i[4:0]] != 16'h0000) begin
          next_s.drv_rd = 1'b1;
          next_s.drv_raddr = s.act_pmap[tx_idx_i[4:0]];
          next_s.tx_zero = 1'b0;
        end
      end
    end
    if (s.tx_pend) begin
      next_s.tx_vld = 1'b1;
      next_s.tx_word = s.tx_zero ? 16'h0000 : drv_rdata_i;
    end
  end

  //----------------------------------------------------------------
  // state register
  //----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.stg_tmo <= iomfs_pkg::TMO_RST;
      s.act_tmo <= iomfs_pkg::TMO_RST;
      s.stg_cmap[0] <= iomfs_pkg::CMAP0_RST;
      s.stg_cmap[1] <= iomfs_pkg::CMAP1_RST;
      s.act_cmap[0] <= iomfs_pkg::CMAP0_RST;
      s.act_cmap[1] <= iomfs_pkg::CMAP1_RST;
      s.stg_pmap[0] <= iomfs_pkg::PMAP0_RST;
      s.stg_pmap[1] <= iomfs_pkg::PMAP1_RST;
      s.act_pmap[0] <= iomfs_pkg::PMAP0_RST;
      s.act_pmap[1] <= iomfs_pkg::PMAP1_RST;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.wb_dat;
  assign wb_ack_o = s.wb_ack;
  assign tx_vld_o = s.tx_vld;
  assign tx_word_o = s.tx_word;
  assign drv_wr_o = s.drv_wr;
  assign drv_waddr_o = s.drv_waddr;
  assign drv_wdata_o = s.drv_wdata;
  assign drv_rd_o = s.drv_rd;
  assign drv_raddr_o = s.drv_raddr;
  assign fs_event_o = s.fs_evt;
  assign online_o = !s.offline;

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_rst_cfg;
    $past(rst_i) |-> s.act_tmo == 16'h03E8 && s.act_fs == '0 &&
      s.act_cmap[0] == 16'h03EF && s.act_cmap[1] == 16'h03F0 &&
      s.act_pmap[0] == 16'h057A && s.act_pmap[1] == 16'h0579;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("reset configuration wrong");

  property p_loss_evt;
    !s.offline && !rx_sof_i && tick && s.armed && !s.lost &&
      s.act_tmo != 16'h0000 && s.silence + 16'h0001 == s.act_tmo
      |=> fs_event_o ##1 !fs_event_o;
  endproperty
  a_loss_evt: assert property (p_loss_evt)
    else $error("loss did not raise one event");

  property p_fs_skip;
    drv_wr_o && s.wr_fs |-> drv_waddr_o != 16'h0000;
  endproperty
  a_fs_skip: assert property (p_fs_skip)
    else $error("disabled fail-safe entry written");

  property p_fs_write;
    s.walk == WALK_RUN && !s.offline && !cons_wr &&
      s.act_fs[s.fs_idx][15:0] != 16'h0000
      |=> drv_wr_o && drv_waddr_o == $past(s.act_fs[s.fs_idx][15:0]) &&
          drv_wdata_o == $past(s.act_fs[s.fs_idx][31:16]);
  endproperty
  a_fs_write: assert property (p_fs_write)
    else $error("fail-safe entry not written");

  property p_fs_order;
    s.walk == WALK_RUN && !cons_wr && !trig && !s.offline
      |=> s.fs_idx == $past(s.fs_idx) + 4'h1;
  endproperty
  a_fs_order: assert property (p_fs_order)
    else $error("fail-safe walk out of order");

  property p_idle_keep;
    rx_sof_i && idle_now && !s.act_idle_fs |=> !fs_event_o && !s.rx_map;
  endproperty
  a_idle_keep: assert property (p_idle_keep)
    else $error("idle packet changed outputs");

  property p_idle_fs;
    !s.offline && rx_sof_i && idle_now && !s.was_idle && s.act_idle_fs
      |=> fs_event_o && s.walk == WALK_RUN && s.fs_idx == 4'h0;
  endproperty
  a_idle_fs: assert property (p_idle_fs)
    else $error("idle did not start fail-safe");

  property p_inst_gate;
    !s.offline && rx_sof_i && rx_inst_i != iomfs_pkg::CONS_INST
      |=> !s.rx_map;
  endproperty
  a_inst_gate: assert property (p_inst_gate)
    else $error("foreign instance mapped");

  property p_tx_zero;
    !s.offline && tx_req_i && s.act_pmap[tx_idx_i[4:0]] == 16'h0000
      |=> !drv_rd_o ##1 tx_vld_o && tx_word_o == 16'h0000;
  endproperty
  a_tx_zero: assert property (p_tx_zero)
    else $error("unmapped produced word not zero");

  property p_tx_word;
    drv_rd_o |=> tx_vld_o && tx_word_o == $past(drv_rdata_i);
  endproperty
  a_tx_word: assert property (p_tx_word)
    else $error("produced word not from register");

  property p_commit;
    bus_req && wb_we_i && widx == OFS_CTRL[9:2] && wb_sel_i[0] &&
      wb_dat_i[iomfs_pkg::CTRL_COMMIT_BIT] |=> !online_o [*2];
  endproperty
  a_commit: assert property (p_commit)
    else $error("commit did not restart");

  c_loss: cover property (s.lost && fs_event_o);
  c_idle: cover property (rx_sof_i && idle_now && s.act_idle_fs);
  c_fs_wr: cover property (drv_wr_o && s.wr_fs);
  c_tx: cover property (drv_rd_o ##1 tx_vld_o);
endmodule
`default_nettype wire

// ---- logic/iomfs_pkg.sv ----
// package: register map, reset values and timing of the io map block
package iomfs_pkg;
  // word-aligned byte offsets on the register bus
  localparam logic [9:0] OFS_CTRL = 10'h000;
  localparam logic [9:0] OFS_TMO = 10'h004;
  localparam logic [9:0] OFS_STAT = 10'h008;
  localparam logic [9:0] OFS_FS = 10'h040;
  localparam logic [9:0] OFS_CMAP = 10'h080;
  localparam logic [9:0] OFS_PMAP = 10'h100;
  // control and status bit positions
  localparam int CTRL_IDLE_FS_BIT = 0;
  localparam int CTRL_COMMIT_BIT = 1;
  localparam int STAT_OFFLINE_BIT = 0;
  localparam int STAT_ARMED_BIT = 1;
  localparam int STAT_LOST_BIT = 2;
  localparam int STAT_WALK_BIT = 3;
  localparam int STAT_IDLE_BIT = 4;
  // fail-safe entry fields
  localparam int FS_REG_LSB = 0;
  localparam int FS_VAL_LSB = 16;
  // reset values
  localparam logic [15:0] TMO_RST = 16'h03E8;
  localparam logic [15:0] CMAP0_RST = 16'h03EF;
  localparam logic [15:0] CMAP1_RST = 16'h03F0;
  localparam logic [15:0] PMAP0_RST = 16'h057A;
  localparam logic [15:0] PMAP1_RST = 16'h0579;
  // assembly instances served by the user map
  localparam logic [7:0] CONS_INST = 8'h64;
  localparam logic [7:0] PROD_INST = 8'h96;
  // timing
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint TMO_STEP_NS = 10000000;
  localparam longint TMO_STEP_CYC = (TMO_STEP_NS * 1000) / CLK_PERIOD_PS;
  localparam longint RESTART_S = 30;
  localparam longint RESTART_CYC =
    (RESTART_S * 1000000000000) / CLK_PERIOD_PS;
endpackage

// ---- testbench/iomfs_drive_model.sv ----
// drive register space model: answers reads, logs writes
`timescale 1ns/1ns
`default_nettype none
module iomfs_drive_model (
  input wire logic clk_i, // clock
  input wire logic wr_i, // register write strobe
  input wire logic [15:0] waddr_i, // written register
  input wire logic [15:0] wdata_i, // written value
  input wire logic rd_i, // register read strobe
  input wire logic [15:0] raddr_i, // read register
  output logic [15:0] rdata_o // read value, while strobe high
);
  logic [31:0] wq [$];
  // ----------------------------------------
  // read answer and write log
  // ----------------------------------------
  // inverse outside reads, so a mistimed sample shows
  always_comb begin
    rdata_o = (rd_i === 1'b1) ? (raddr_i ^ 16'h5A3C) : ~(raddr_i ^ 16'h5A3C);
  end
  always @(posedge clk_i) begin
    if (wr_i === 1'b1) begin
      wq.push_back({waddr_i, wdata_i});
    end
  end
endmodule
`default_nettype wire

// ---- testbench/iomfs_core_bench.sv ----
// self-checking bench of the io word mapper and fail-safe writer
`timescale 1ns/1ns
`default_nettype none
module iomfs_core_bench;
  localparam longint TICKS = 4;
  localparam longint RESTART = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, sof, hdrv, wv, txr, ack, txv, dwr, drd, fse, onl;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, hdr;
  logic [31:0] seed = 32'h0000D82F;
  logic [7:0] rinst, tinst;
  logic [5:0] tidx;
  logic [15:0] word, txw, dwa, dwd, dra, drdat;
  logic [15:0] wbuf [32];
  logic [15:0] txq [$];
  int err_count = 0;
  int checks_done = 0;
  int ev_cnt = 0;
  int lowcnt = 0;

  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (fse === 1'b1) ev_cnt++;
    if (onl === 1'b0) lowcnt++;
    if (txv === 1'b1) txq.push_back(txw);
  end

  iomfs_core #(.TICK_CYC(TICKS), .RESTART_CYC(RESTART)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rx_sof_i(sof), .rx_inst_i(rinst),
    .rx_hdr_vld_i(hdrv), .rx_hdr_i(hdr), .rx_word_vld_i(wv),
    .rx_word_i(word), .tx_req_i(txr), .tx_inst_i(tinst), .tx_idx_i(tidx),
    .tx_vld_o(txv), .tx_word_o(txw), .drv_wr_o(dwr), .drv_waddr_o(dwa),
    .drv_wdata_o(dwd), .drv_rd_o(drd), .drv_raddr_o(dra),
    .drv_rdata_i(drdat), .fs_event_o(fse), .online_o(onl));

  iomfs_drive_model drv (.clk_i(clk_i), .wr_i(dwr), .waddr_i(dwa),
    .wdata_i(dwd), .rd_i(drd), .raddr_i(dra), .rdata_o(drdat));

  // ----------------------------------------
  // expectations and checks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] drv_val(input logic [15:0] a);
    return a ^ 16'h5A3C;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic expect_wr(input logic [15:0] a, input logic [15:0] d);
    logic [31:0] g;
    g = 'x;
    if (drv.wq.size() > 0) g = drv.wq.pop_front();
    chk(g, {a, d}, "drive write");
  endtask
  task automatic expect_tx(input logic [15:0] d);
    logic [15:0] g;
    g = 'x;
    if (txq.size() > 0) g = txq.pop_front();
    chk({16'h0000, g}, {16'h0000, d}, "produced word");
  endtask
  task automatic no_wr();
    chk(32'(drv.wq.size()), 32'h00000000, "unexpected drive write");
  endtask

  // ----------------------------------------
  // bus, link and control drivers
  // ----------------------------------------
  task automatic wb(input logic w, input logic [9:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    chk({31'h0, ack}, 32'h00000001, "bus acknowledge");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wbw(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h00000000, q);
    chk(q, e, "register read");
  endtask
  task automatic pkt(input logic [7:0] inst, input logic hv,
                     input logic [31:0] h, input int nw);
    @(posedge clk_i);
    sof <= 1'b1;
    rinst <= inst;
    hdrv <= hv;
    hdr <= h;
    @(posedge clk_i);
    sof <= 1'b0;
    for (int i = 0; i < nw; i++) begin
      if (i > 0) @(posedge clk_i);
      wv <= 1'b1;
      word <= wbuf[i];
    end
    @(posedge clk_i);
    wv <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic txs(input logic [7:0] inst, input logic [5:0] i0,
                     input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      txr <= 1'b1;
      tinst <= inst;
      tidx <= i0 + 6'(i);
    end
    @(posedge clk_i);
    txr <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic commit(input logic opt);
    int n;
    n = 0;
    lowcnt = 0;
    wbw(iomfs_pkg::OFS_CTRL, {30'h0, 1'b1, opt});
    pkt(iomfs_pkg::CONS_INST, 1'b0, 32'h0, 2);
    while (onl !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(lowcnt >= RESTART && lowcnt <= RESTART + 1), 32'h1, "restart");
    no_wr();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    int n;
    int e0;
    logic [15:0] v [10];
    {cyc, stb, we, sof, hdrv, wv, txr} = '0;
    {adr, sel, wdat, hdr, rinst, tinst, tidx, word} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(iomfs_pkg::OFS_TMO, 32'h000003E8);
    for (int i = 0; i < 10; i++) begin
      rdchk(iomfs_pkg::OFS_FS + 10'(4 * i), 32'h0);
    end
    rdchk(iomfs_pkg::OFS_CMAP, 32'h000003EF);
    rdchk(iomfs_pkg::OFS_CMAP + 10'h004, 32'h000003F0);
    rdchk(iomfs_pkg::OFS_CMAP + 10'h07C, 32'h0);
    rdchk(iomfs_pkg::OFS_PMAP, 32'h0000057A);
    rdchk(iomfs_pkg::OFS_PMAP + 10'h004, 32'h00000579);
    rdchk(10'h3FC, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 32; i++) wbuf[i] = 16'(rnd());
    pkt(iomfs_pkg::CONS_INST, 1'b1, rnd() | 32'h1, 3);
    expect_wr(16'h03EF, wbuf[0]);
    expect_wr(16'h03F0, wbuf[1]);
    no_wr();
    pkt(8'h65, 1'b0, 32'h0, 2);
    no_wr();
    e0 = ev_cnt;
    pkt(iomfs_pkg::CONS_INST, 1'b1, rnd() & 32'hFFFFFFFE, 2);
    no_wr();
    chk(32'(ev_cnt - e0), 32'h0, "idle event with option clear");
    txs(iomfs_pkg::PROD_INST, 6'h00, 3);
    expect_tx(drv_val(16'h057A));
    expect_tx(drv_val(16'h0579));
    expect_tx(16'h0000);
    txs(8'h97, 6'h00, 1);
    expect_tx(16'h0000);
    txs(iomfs_pkg::PROD_INST, 6'h28, 1);
    expect_tx(16'h0000);
    $display("test default mapping done");
    for (int i = 0; i < 10; i++) v[i] = 16'(rnd());
    wbw(iomfs_pkg::OFS_CMAP, 32'h00000111);
    wbw(iomfs_pkg::OFS_CMAP + 10'h07C, 32'h00000333);
    wbw(iomfs_pkg::OFS_PMAP + 10'h008, 32'h00000400);
    wbw(iomfs_pkg::OFS_FS, {v[0], 16'h0000});
    wbw(iomfs_pkg::OFS_FS + 10'h004, {v[1], 16'h0100});
    wbw(iomfs_pkg::OFS_FS + 10'h00C, {v[3], 16'h0200});
    wbw(iomfs_pkg::OFS_FS + 10'h024, {v[9], 16'h0300});
    wbw(iomfs_pkg::OFS_TMO, 32'h0);
    rdchk(iomfs_pkg::OFS_CMAP, 32'h00000111);
    pkt(iomfs_pkg::CONS_INST, 1'b0, 32'h0, 1);
    expect_wr(16'h03EF, wbuf[0]);
    commit(1'b1);
    rdchk(iomfs_pkg::OFS_CTRL, 32'h00000001);
    $display("test staged commit done");
    pkt(iomfs_pkg::CONS_INST, 1'b1, 32'h1, 32);
    expect_wr(16'h0111, wbuf[0]);
    expect_wr(16'h03F0, wbuf[1]);
    expect_wr(16'h0333, wbuf[31]);
    no_wr();
    txs(iomfs_pkg::PROD_INST, 6'h00, 3);
    expect_tx(drv_val(16'h057A));
    expect_tx(drv_val(16'h0579));
    expect_tx(drv_val(16'h0400));
    e0 = ev_cnt;
    pkt(iomfs_pkg::CONS_INST, 1'b1, rnd() & 32'hFFFFFFFE, 2);
    repeat (20) @(posedge clk_i);
    chk(32'(ev_cnt - e0), 32'h1, "idle event with option set");
    expect_wr(16'h0100, v[1]);
    expect_wr(16'h0200, v[3]);
    expect_wr(16'h0300, v[9]);
    no_wr();
    $display("test idle fail-safe done");
    wbw(iomfs_pkg::OFS_TMO, 32'h00000003);
    commit(1'b0);
    e0 = ev_cnt;
    pkt(iomfs_pkg::CONS_INST, 1'b0, 32'h0, 0);
    chk(32'(ev_cnt - e0), 32'h0, "early timeout event");
    n = 0;
    while (ev_cnt == e0 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n <= 3 * TICKS + 2), 32'h1, "timeout delay");
    repeat (40) @(posedge clk_i);
    chk(32'(ev_cnt - e0), 32'h1, "timeout event count");
    expect_wr(16'h0100, v[1]);
    expect_wr(16'h0200, v[3]);
    expect_wr(16'h0300, v[9]);
    no_wr();
    rdchk(iomfs_pkg::OFS_STAT, 32'h00000006);
    $display("test silence timeout done");
    report_and_stop();
  end
endmodule
`default_nettype wire
